/* hw/acc_justify.sv */
// Result formatter: places the 10-bit result left or right in a 16-bit word.
`timescale 1ns/1ps
module acc_justify (
  // Core link
  acc_link_if.fmt_mp lnk
);
  import acc_pkg::*;

  always_comb begin
    if (lnk.justify) begin
      lnk.word = {6'h00, lnk.raw};
    end else begin
      lnk.word = {lnk.raw, 6'h00};
    end
  end

endmodule : acc_justify

/* hw/acc_link_if.sv */
// Interface joining the control core to its bit-period divider and result formatter.
`timescale 1ns/1ps
interface acc_link_if;
  logic        run;
  logic        restart;
  logic [2:0]  clk_sel;
  logic        tick;
  logic [9:0]  raw;
  logic        justify;
  logic [15:0] word;

  modport tad_mp  (input run, input restart, input clk_sel, output tick);
  modport fmt_mp  (input raw, input justify, output word);
  modport core_mp (output run, output restart, output clk_sel, output raw, output justify,
                   input tick, input word);
endinterface : acc_link_if

/* hw/acc_pkg.sv */
// Shared constants, state encoding and divider decode for the conversion control block.
package acc_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  localparam int         ADDR_W          = 8;
  localparam int         DATA_W          = 32;
  localparam int         RES_W           = 10;
  localparam int         WORD_W          = 16;

  localparam logic [7:0] OFF_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] OFF_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFF_RES_HIGH    = 8'h08;
  localparam logic [7:0] OFF_RES_LOW     = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////////////////
  localparam int         CF_EN_BIT       = 0;
  localparam int         CF_GO_BIT       = 2;
  localparam int         CF_CHAN_LSB     = 3;
  localparam int         CF_CLK_LSB      = 6;
  localparam int         CS_PCFG_LSB     = 0;
  localparam int         CS_CLKHI_BIT    = 6;
  localparam int         CS_JUST_BIT     = 7;
  localparam int         IRQ_DONE_BIT    = 0;
  localparam int         IRQ_ABORT_BIT   = 1;

  localparam logic [7:0] CTRL_FIRST_RST  = 8'h00;
  localparam logic [7:0] CTRL_SECOND_RST = 8'h00;
  localparam logic [7:0] RESULT_RST      = 8'h00;
  localparam logic [1:0] IRQ_RST         = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////////////////
  localparam logic [3:0] CMP_MODE_TRIG   = 4'hB;
  localparam logic [3:0] CONV_TADS       = 4'hC;
  localparam logic [3:0] ABORT_TADS      = 4'h2;
  localparam int         CLK_PERIOD_NS   = 40;
  localparam int         RC_TAD_NS       = 4000;
  localparam int         RC_TAD_CYC      = RC_TAD_NS / CLK_PERIOD_NS;

  localparam logic [2:0] TAD_SEL_2       = 3'h0;
  localparam logic [2:0] TAD_SEL_8       = 3'h1;
  localparam logic [2:0] TAD_SEL_32      = 3'h2;
  localparam logic [2:0] TAD_SEL_4       = 3'h4;
  localparam logic [2:0] TAD_SEL_16      = 3'h5;
  localparam logic [2:0] TAD_SEL_64      = 3'h6;

  typedef enum logic [3:0] {
    ST_OFF  = 4'h1,
    ST_ACQ  = 4'h2,
    ST_CONV = 4'h4,
    ST_WAIT = 4'h8
  } acc_state_e;

  // Codes 011 and 111 both pick the internal RC period.
  function automatic logic [7:0] acc_tad_cycles(input logic [2:0] sel,
                                                input logic [7:0] rc_div);
    logic [7:0] n;
    n = rc_div;
    if (sel == TAD_SEL_2)  n = 8'h02;
    if (sel == TAD_SEL_4)  n = 8'h04;
    if (sel == TAD_SEL_8)  n = 8'h08;
    if (sel == TAD_SEL_16) n = 8'h10;
    if (sel == TAD_SEL_32) n = 8'h20;
    if (sel == TAD_SEL_64) n = 8'h40;
    return n;
  endfunction : acc_tad_cycles

endpackage : acc_pkg

/* hw/acc_tad_div.sv */
// Bit-period divider: one-cycle tick every selected number of core clock periods.
`timescale 1ns/1ps
module acc_tad_div #(
  parameter logic [7:0] RC_DIV = 8'(acc_pkg::RC_TAD_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core link
  acc_link_if.tad_mp lnk
);
  import acc_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] period;
  logic       tick_q;

  always_comb begin
    period = acc_tad_cycles(lnk.clk_sel, RC_DIV);
  end

  // Restart realigns the phase so a wait is counted from the abort itself.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (!lnk.run || lnk.restart) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (cnt_q == period - 8'h01);
      cnt_q  <= (cnt_q == period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    end
  end

  assign lnk.tick = tick_q;

endmodule : acc_tad_div

/* hw/acc_top.sv */
// Conversion control core with Wishbone register slave and completion interrupt.
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps

// Functional notes
// - Clearing start/done during a conversion aborts it at once, unless a trigger comes in the same cycle.
// - An aborted conversion leaves both result registers unchanged unless the abort lands in the cycle that completes it.
// - After an abort wait two bit periods, then acquire again by itself.
// - A finished conversion loads its 10-bit result into the 16-bit pair.
// - The justify bit chooses left or right placement of the result.
// - Unused six bits of the pair are loaded with zeros.
// - While disabled the result registers are plain readable writable bytes.
// - Trigger with mode 1011 and enable set, while acquiring, sets start/done and converts.
// - Every matching trigger clears the associated timer counter.
// - With enable clear a trigger starts nothing but still clears the timer.
// - Unimplemented control bits read zero and ignore writes.
// - A conversion lasts twelve bit periods plus one clock cycle until the result loads.
// - Clock select picks 2 to 64 oscillator periods or internal RC.
module acc_top #(
  parameter logic [7:0] RC_DIV = 8'(acc_pkg::RC_TAD_CYC)
) (
  // Clock and reset
  input  wire logic                        SYS_CLK,
  input  wire logic                        RST_N,
  // Wishbone slave
  input  wire logic                        WB_CYC_I,
  input  wire logic                        WB_STB_I,
  input  wire logic                        WB_WE_I,
  input  wire logic [acc_pkg::ADDR_W-1:0]  WB_ADR_I,
  input  wire logic [3:0]                  WB_SEL_I,
  input  wire logic [acc_pkg::DATA_W-1:0]  WB_DAT_I,
  output logic      [acc_pkg::DATA_W-1:0]  WB_DAT_O,
  output logic                             WB_ACK_O,
  // Compare unit
  input  wire logic [3:0]                  COMPARE_MODE,
  input  wire logic                        SPECIAL_EVENT,
  output logic                             TIMER_CLEAR,
  // Analog converter
  input  wire logic [acc_pkg::RES_W-1:0]   ADC_RESULT,
  output logic                             ACQ_ON,
  output logic                             CONV_ON,
  output logic [2:0]                       CHANNEL_SEL,
  output logic [3:0]                       PORT_CONFIG,
  // Interrupt
  output logic                             IRQ
);
  import acc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////
  acc_state_e  state_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        en_q;
  logic        go_q;
  logic [2:0]  chan_q;
  logic [1:0]  clk_lo_q;
  logic        clk_hi_q;
  logic        just_q;
  logic [3:0]  pcfg_q;
  logic [7:0]  res_hi_q;
  logic [7:0]  res_lo_q;
  logic [1:0]  stat_q;
  logic [1:0]  mask_q;
  logic [1:0]  stat_d;
  logic        irq_q;
  logic        tmr_clr_q;
  logic [3:0]  bit_cnt_q;
  logic        acq_q;
  logic        conv_q;

  logic        wr_hit;
  logic        wr_ctl0;
  logic        wr_ctl1;
  logic        wr_hi;
  logic        wr_lo;
  logic        wr_stat;
  logic        wr_mask;
  logic [7:0]  wd;
  logic        trig;
  logic        start_sw;
  logic        start_hw;
  logic        start;
  logic        abort_sw;
  logic        done;
  logic        wait_done;
  logic [7:0]  rmux;

  acc_link_if lnk ();

  acc_tad_div #(
    .RC_DIV (RC_DIV)
  ) u_div (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .lnk   (lnk)
  );

  acc_justify u_fmt (
    .lnk (lnk)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Bus decode. A write lands on the edge at which the master sees ack.
  always_comb begin
    wd       = WB_DAT_I[7:0];
    wr_hit   = WB_CYC_I && WB_STB_I && ack_q && WB_WE_I && WB_SEL_I[0];
    wr_ctl0  = wr_hit && (WB_ADR_I == OFF_CTRL_FIRST);
    wr_ctl1  = wr_hit && (WB_ADR_I == OFF_CTRL_SECOND);
    wr_hi    = wr_hit && (WB_ADR_I == OFF_RES_HIGH);
    wr_lo    = wr_hit && (WB_ADR_I == OFF_RES_LOW);
    wr_stat  = wr_hit && (WB_ADR_I == OFF_IRQ_STATUS);
    wr_mask  = wr_hit && (WB_ADR_I == OFF_IRQ_MASK);
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Start, abort and completion decisions.
  always_comb begin
    trig      = SPECIAL_EVENT && (COMPARE_MODE == CMP_MODE_TRIG);
    // Enable must already be on before the write; this keeps a start out of the
    // write that powers the converter up, where no acquisition has happened.
    start_sw  = wr_ctl0 && wd[CF_GO_BIT] && wd[CF_EN_BIT] && en_q &&
                (state_q == ST_ACQ);
    start_hw  = trig && en_q && (state_q == ST_ACQ);
    start     = start_sw || start_hw;
    // A trigger in the same cycle as the clearing write keeps the bit set.
    abort_sw  = (state_q == ST_CONV) && wr_ctl0 && !wd[CF_GO_BIT] && !trig;
    done      = (state_q == ST_CONV) && lnk.tick && (bit_cnt_q == CONV_TADS - 4'h1);
    wait_done = (state_q == ST_WAIT) && lnk.tick && (bit_cnt_q == ABORT_TADS - 4'h1);
  end

  always_comb begin
    lnk.run     = (state_q == ST_CONV) || (state_q == ST_WAIT);
    lnk.restart = start || abort_sw;
    lnk.clk_sel = {clk_hi_q, clk_lo_q};
    lnk.raw     = ADC_RESULT;
    lnk.justify = just_q;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_OFF;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          if (en_q) state_q <= ST_ACQ;
        end
        ST_ACQ: begin
          if (!en_q) state_q <= ST_OFF;
          else if (start) state_q <= ST_CONV;
        end
        ST_CONV: begin
          if (!en_q) state_q <= ST_OFF;
          else if (abort_sw) state_q <= ST_WAIT;
          else if (done) state_q <= ST_ACQ;
        end
        ST_WAIT: begin
          if (!en_q) state_q <= ST_OFF;
          else if (wait_done) state_q <= ST_ACQ;
        end
      endcase
    end
  end

  // Counts bit periods inside a conversion or an abort wait.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_cnt_q <= 4'h0;
    end else if (!lnk.run || lnk.restart) begin
      bit_cnt_q <= 4'h0;
    end else if (lnk.tick) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // Outputs to the analog side follow the sequencer one cycle later.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acq_q  <= 1'b0;
      conv_q <= 1'b0;
    end else begin
      acq_q  <= (state_q == ST_ACQ);
      conv_q <= (state_q == ST_CONV);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Start/done bit: hardware set wins over a clearing write.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      go_q <= 1'b0;
    end else if (start) begin
      go_q <= 1'b1;
    end else if (done || !en_q) begin
      go_q <= 1'b0;
    end else if (wr_ctl0 && !wd[CF_GO_BIT] && !trig) begin
      go_q <= 1'b0;
    end
  end

  // Control fields. Bit 1 of the first and bits 5:4 of the second are not stored.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_q     <= CTRL_FIRST_RST[CF_EN_BIT];
      chan_q   <= CTRL_FIRST_RST[CF_CHAN_LSB +: 3];
      clk_lo_q <= CTRL_FIRST_RST[CF_CLK_LSB +: 2];
    end else if (wr_ctl0) begin
      en_q     <= wd[CF_EN_BIT];
      chan_q   <= wd[CF_CHAN_LSB +: 3];
      clk_lo_q <= wd[CF_CLK_LSB +: 2];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pcfg_q   <= CTRL_SECOND_RST[CS_PCFG_LSB +: 4];
      clk_hi_q <= CTRL_SECOND_RST[CS_CLKHI_BIT];
      just_q   <= CTRL_SECOND_RST[CS_JUST_BIT];
    end else if (wr_ctl1) begin
      pcfg_q   <= wd[CS_PCFG_LSB +: 4];
      clk_hi_q <= wd[CS_CLKHI_BIT];
      just_q   <= wd[CS_JUST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Result pair: a completed conversion overrides a software write in the same cycle.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      res_hi_q <= RESULT_RST;
      res_lo_q <= RESULT_RST;
    end else if (done) begin
      res_hi_q <= lnk.word[15:8];
      res_lo_q <= lnk.word[7:0];
    end else begin
      if (wr_hi) res_hi_q <= wd;
      if (wr_lo) res_lo_q <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear; a new event in the clearing cycle survives.
  always_comb begin
    stat_d = stat_q;
    if (wr_stat) stat_d = stat_q & ~wd[1:0];
    if (done) stat_d[IRQ_DONE_BIT] = 1'b1;
    if (abort_sw) stat_d[IRQ_ABORT_BIT] = 1'b1;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_q <= IRQ_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_q <= IRQ_RST;
    end else if (wr_mask) begin
      mask_q <= wd[1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Timer clear goes out for every matching trigger, enabled or not.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tmr_clr_q <= 1'b0;
    end else begin
      tmr_clr_q <= trig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses answer with zero.
  always_comb begin
    unique case (WB_ADR_I)
      OFF_CTRL_FIRST:  rmux = {clk_lo_q, chan_q, go_q, 1'b0, en_q};
      OFF_CTRL_SECOND: rmux = {just_q, clk_hi_q, 2'h0, pcfg_q};
      OFF_RES_HIGH:    rmux = res_hi_q;
      OFF_RES_LOW:     rmux = res_lo_q;
      OFF_IRQ_STATUS:  rmux = {6'h00, stat_q};
      OFF_IRQ_MASK:    rmux = {6'h00, mask_q};
      default:         rmux = 8'h00;
    endcase
  end

  // One wait state: ack and read data come one cycle after the request is seen.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
      if (WB_CYC_I && WB_STB_I && !ack_q) begin
        rdata_q <= {24'h00_0000, rmux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  assign WB_DAT_O    = rdata_q;
  assign WB_ACK_O    = ack_q;
  assign TIMER_CLEAR = tmr_clr_q;
  assign ACQ_ON      = acq_q;
  assign CONV_ON     = conv_q;
  assign CHANNEL_SEL = chan_q;
  assign PORT_CONFIG = pcfg_q;
  assign IRQ         = irq_q;

endmodule : acc_top

/* verif/acc_adc_model.sv */
// Behavioural model of the sample-and-hold converter behind the block.
`timescale 1ns/1ps
module acc_adc_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Converter control
  input  wire logic       conv_on,
  input  wire logic [2:0] chan,
  // Result
  output logic      [9:0] result
);
  // Outside a conversion the lines toggle, so a stale sample is never taken for a fresh one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 10'h000;
    end else if (conv_on) begin
      result <= {chan, 7'h2B};
    end else begin
      result <= ~result;
    end
  end
endmodule : acc_adc_model

/* verif/acc_top_sva.sv */
// Port-level checker for the conversion control block.
`timescale 1ns/1ps
module acc_top_sva (
  // Clock and reset
  input wire logic                       SYS_CLK,
  input wire logic                       RST_N,
  // Register bus
  input wire logic                       WB_CYC_I,
  input wire logic                       WB_STB_I,
  input wire logic [acc_pkg::DATA_W-1:0] WB_DAT_O,
  input wire logic                       WB_ACK_O,
  // Compare unit and converter
  input wire logic [3:0]                 COMPARE_MODE,
  input wire logic                       SPECIAL_EVENT,
  input wire logic                       TIMER_CLEAR,
  input wire logic                       ACQ_ON,
  input wire logic                       CONV_ON,
  input wire logic                       IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire trig = SPECIAL_EVENT && COMPARE_MODE == acc_pkg::CMP_MODE_TRIG;

  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered in one cycle");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  read_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("unused read data bits not zero");
  timer_clear_a: assert property (trig |=> TIMER_CLEAR)
    else $error("trigger did not clear the timer");
  timer_cause_a: assert property (TIMER_CLEAR |-> $past(trig))
    else $error("timer cleared without a trigger");
  phase_excl_a: assert property (!(ACQ_ON && CONV_ON))
    else $error("acquire and convert at once");
  conv_from_acq_a: assert property ($rose(CONV_ON) |-> $past(ACQ_ON))
    else $error("conversion started outside acquisition");
  reset_quiet_a: assert property ($rose(RST_N) |-> !IRQ && !CONV_ON && !ACQ_ON && !WB_ACK_O)
    else $error("outputs active right after reset");

  cover property ($rose(CONV_ON));
  cover property ($fell(CONV_ON) && !ACQ_ON);
  cover property (trig && ACQ_ON);
  cover property ($rose(IRQ));
endmodule : acc_top_sva

bind acc_top acc_top_sva i_sva (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_DAT_O, .WB_ACK_O,
  .COMPARE_MODE, .SPECIAL_EVENT, .TIMER_CLEAR, .ACQ_ON, .CONV_ON, .IRQ);

/* verif/tb.sv */
// Self-checking testbench for the conversion control block.
`timescale 1ns/1ps
module tb;
  import acc_pkg::*;
  logic        sys_clk, rst_n, req, we, sev, ack, tclr, acq, conv, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, dat_o, rd;
  logic [3:0]  mode, pcfg, sel;
  logic [9:0]  adc, res;
  logic [2:0]  chan, sl;
  int          num_errors, n_checks, cnt;
  int          tads [8] = '{2, 8, 32, 3, 4, 16, 64, 3};

  acc_top #(.RC_DIV(8'h03)) i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .WB_CYC_I(req),
    .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .COMPARE_MODE(mode), .SPECIAL_EVENT(sev),
    .TIMER_CLEAR(tclr), .ADC_RESULT(adc), .ACQ_ON(acq), .CONV_ON(conv),
    .CHANNEL_SEL(chan), .PORT_CONFIG(pcfg), .IRQ(irq));
  acc_adc_model i_adc (.clk(sys_clk), .rst_n(rst_n), .conv_on(conv), .chan(chan), .result(adc));

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Request is held until ack is sampled; the bound stands in for a hung slave.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    rd = dat_o;
    req <= 1'b0;
    @(posedge sys_clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 8'h00, 4'h1);
    chk(nm, rd, e);
  endtask : rdc

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : ticks

  task automatic pulse(input logic [3:0] m);
    mode <= m;
    sev <= 1'b1;
    @(posedge sys_clk);
    sev <= 1'b0;
    @(posedge sys_clk);
  endtask : pulse

  // Counts the cycles that CONV_ON stays high for one conversion.
  task automatic conv_wait();
    int n;
    cnt = 0;
    for (n = 0; n < 2000; n++) begin
      @(posedge sys_clk);
      if (conv === 1'b1) cnt++;
      else if (cnt > 0) break;
    end
    if (n == 2000) begin
      num_errors++;
      stop_test();
    end
  endtask : conv_wait

  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    int n;
    rst_n = 1'b0;
    req = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    mode = 4'h0;
    sev = 1'b0;
    num_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (n = 0; n < 6; n++) rdc(8'(4 * n), 32'h0, "reset value");
    rdc(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    wr(OFF_CTRL_FIRST, 8'hFF);
    rdc(OFF_CTRL_FIRST, 32'hF9, "ctrl_first");
    wr(OFF_CTRL_SECOND, 8'hFF);
    rdc(OFF_CTRL_SECOND, 32'hCF, "ctrl_second");
    chk("channel", 32'(chan), 32'h7);
    chk("port_cfg", 32'(pcfg), 32'hF);
    wr(OFF_CTRL_FIRST, 8'h00);
    wr(OFF_RES_HIGH, 8'hA5);
    wr(OFF_RES_LOW, 8'h5A);
    // A write with the low byte lane off must leave the byte alone.
    wb(1'b1, OFF_RES_HIGH, 8'h00, 4'h2);
    rdc(OFF_RES_HIGH, 32'hA5, "res_high");
    rdc(OFF_RES_LOW, 32'h5A, "res_low");
    $display("test registers done");
    for (int s = 0; s < 8; s++) begin
      sl = 3'(s);
      res = {sl, 7'h2B};
      wr(OFF_CTRL_SECOND, {1'b1, sl[2], 6'h00});
      wr(OFF_CTRL_FIRST, {sl[1:0], sl, 3'h1});
      wr(OFF_CTRL_FIRST, {sl[1:0], sl, 3'h5});
      conv_wait();
      chk("conv_len", 32'(cnt >= 12 * tads[s] && cnt <= 12 * tads[s] + 1), 32'h1);
      rdc(OFF_RES_HIGH, 32'(res[9:8]), "right high");
      rdc(OFF_RES_LOW, 32'(res[7:0]), "right low");
      rdc(OFF_IRQ_STATUS, 32'h1, "done status");
      wr(OFF_IRQ_STATUS, 8'h01);
    end
    $display("test clock select done");
    res = {3'h5, 7'h2B};
    wr(OFF_CTRL_SECOND, 8'h00);
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_CTRL_FIRST, 8'h29);
    wr(OFF_CTRL_FIRST, 8'h2D);
    conv_wait();
    ticks(3);
    chk("irq", 32'(irq), 32'h1);
    rdc(OFF_RES_HIGH, 32'(res[9:2]), "left high");
    rdc(OFF_RES_LOW, {24'h0, res[1:0], 6'h00}, "left low");
    rdc(OFF_CTRL_FIRST, 32'h29, "go clear");
    wr(OFF_IRQ_STATUS, 8'h01);
    ticks(3);
    chk("irq", 32'(irq), 32'h0);
    $display("test justify done");
    wr(OFF_IRQ_MASK, 8'h00);
    wr(OFF_CTRL_FIRST, 8'h2D);
    ticks(6);
    wr(OFF_CTRL_FIRST, 8'h29);
    ticks(2);
    chk("conv abort", 32'(conv), 32'h0);
    chk("acq wait", 32'(acq), 32'h0);
    for (n = 0; n < 8 && acq !== 1'b1; n++) @(posedge sys_clk);
    chk("acq restart", 32'(acq), 32'h1);
    rdc(OFF_RES_HIGH, 32'(res[9:2]), "kept high");
    rdc(OFF_RES_LOW, {24'h0, res[1:0], 6'h00}, "kept low");
    rdc(OFF_IRQ_STATUS, 32'h2, "abort status");
    chk("irq masked", 32'(irq), 32'h0);
    wr(OFF_IRQ_MASK, 8'h02);
    ticks(3);
    chk("irq", 32'(irq), 32'h1);
    wr(OFF_IRQ_STATUS, 8'h02);
    ticks(3);
    chk("irq", 32'(irq), 32'h0);
    $display("test abort done");
    // Channel 5 stays selected and acquisition has run long before the trigger.
    // The 64-period select gives a bit period above the converter's minimum.
    wr(OFF_CTRL_SECOND, 8'h40);
    wr(OFF_CTRL_FIRST, 8'hA9);
    pulse(4'hA);
    chk("timer_clear", 32'(tclr), 32'h0);
    ticks(2);
    chk("conv", 32'(conv), 32'h0);
    pulse(CMP_MODE_TRIG);
    chk("timer_clear", 32'(tclr), 32'h1);
    conv_wait();
    chk("trig len", 32'(cnt >= 12 * 64 && cnt <= 12 * 64 + 1), 32'h1);
    rdc(OFF_IRQ_STATUS, 32'h1, "trig done");
    wr(OFF_CTRL_FIRST, 8'hA8);
    pulse(CMP_MODE_TRIG);
    chk("timer_clear", 32'(tclr), 32'h1);
    ticks(3);
    chk("conv", 32'(conv), 32'h0);
    rdc(OFF_CTRL_FIRST, 32'hA8, "no go");
    $display("test trigger done");
    stop_test();
  end
endmodule : tb
